// [rtl/modem_ctrl_defines.svh]
// register indices, field positions, reset values and timing constants
// assumes byte address equals four times the register index
`ifndef MODEM_CTRL_DEFINES_SVH
`define MODEM_CTRL_DEFINES_SVH

`define IDX_RX_BURST_LEN_LOW        8'h2E
`define IDX_RX_PROBE_SELECT         8'h38
`define IDX_FILTER_SECTION_POWER_OFF 8'h39
`define IDX_RX_BURST_LEN_HIGH       8'h3A
`define IDX_LOOPBACK_OVERLAY_CTRL   8'h3B
`define IDX_TX_MODE_CTRL            8'h40
`define IDX_TX_CHIP_DIVIDER         8'h41
`define IDX_TX_CHIPS_PER_SYMBOL     8'h42
`define IDX_BLOCK_STATUS            8'h5F

`define RST_BYTE                    8'h00
`define RST_CHIP_DIVIDER            6'h01
`define RST_CHIPS_PER_SYMBOL        6'h0F

`define LB_MF_BIT                   0
`define LB_IF_BIT                   1
`define OVL_SEL_LSB                 2
`define TXM_BPSK_BIT                0
`define TXM_OFFSET_BIN_BIT          1
`define TXM_MANUAL_CHIP_BIT         2
`define TXM_INVERT_SYM_BIT          3

`define BURST_OVERHEAD              16'h0002
`define OVERLAY_SEED                10'h3FF
`define IF_MSB_FLIP                 8'h80
`define MF_SECTIONS                 7

`endif

// [rtl/modem_ctrl_pkg.sv]
// shared types of the burst modem control block
// assumes the defines header is included by the users
package modem_ctrl_pkg;
    typedef enum logic {
        RX_ACQ,
        RX_DATA
    } rx_mode_e;

    typedef enum logic [1:0] {
        OVL_OFF,
        OVL_63,
        OVL_511,
        OVL_1023
    } overlay_sel_e;

    typedef logic [127:0] probe_points_t;
    typedef logic [7:0]   sample_t;
endpackage

// [rtl/modem_sub_ifs.sv]
// carriers between the control top and its two helper modules
// assumes a single clock shared by all parties
`timescale 1ns/1ns
interface overlay_if;
    import modem_ctrl_pkg::*;
    overlay_sel_e sel;
    logic         restart;
    logic         step;
    logic         code_bit;
    modport gen  (input sel, input restart, input step, output code_bit);
    modport user (output sel, output restart, output step, input code_bit);
endinterface

interface chip_div_if;
    logic [5:0] div;
    logic       run;
    logic       tick;
    modport gen  (input div, input run, output tick);
    modport user (output div, output run, input tick);
endinterface

// [rtl/chip_divider.sv]
// internal chip clock generator: one tick every div+1 clocks
// assumes div is at least one while run is high
`timescale 1ns/1ns
module chip_divider (
    input  wire logic  pclk,
    input  wire logic  presetn,
    chip_div_if.gen    cd
);
    import modem_ctrl_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } div_state_s;

    div_state_s st;
    div_state_s next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (!cd.run) begin
            next_st.cnt = 6'h00;
        end else if (st.cnt >= cd.div) begin
            next_st.cnt  = 6'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cd.tick = st.tick;
endmodule

// [rtl/overlay_gen.sv]
// receiver overlay code generator, one code bit per step
// assumes restart is pulsed at the start of each burst
`timescale 1ns/1ns
`include "modem_ctrl_defines.svh"
module overlay_gen (
    input  wire logic  pclk,
    input  wire logic  presetn,
    overlay_if.gen     ov
);
    import modem_ctrl_pkg::*;

    typedef struct packed {
        logic [9:0] lfsr;
    } ovl_state_s;

    ovl_state_s st;
    ovl_state_s next_st;
    logic       fb;

    // taps x2 x3 x5 common to all three codes, top tap by length
    always_comb begin
        next_st = st;
        fb      = st.lfsr[1] ^ st.lfsr[2] ^ st.lfsr[4];
        case (ov.sel)
            OVL_63:   fb = fb ^ st.lfsr[5];
            OVL_511:  fb = fb ^ st.lfsr[8];
            OVL_1023: fb = fb ^ st.lfsr[9];
            default:  fb = 1'b0;
        endcase
        if (ov.restart) begin
            next_st.lfsr = `OVERLAY_SEED;
        end else if (ov.step && ov.sel != OVL_OFF) begin
            next_st.lfsr = {st.lfsr[8:0], fb};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ov.code_bit = (ov.sel != OVL_OFF) & st.lfsr[0];
endmodule

// [rtl/burst_modem_test_tx_control.sv]
// control registers, receiver test routing and transmit data request
// assumes pclk is both IF clocks; all pins synchronous except the
// manual chip pulse, which is synchronised here
//
// Behaviour
// - probe select picks one of sixteen receiver test points for probe bus
// - receiver disable clears probe select to zero
// - power-saver bit k turns off filter taps 9k+1 to 9k+9
// - acquisition mode keeps every tap section powered
// - tap zero has no power control and stays on
// - burst length is 16 bits in two bytes; data symbols are value minus two
// - burst ends after the programmed symbols; receiver returns to acquisition
// - filter loopback feeds transmit I and Q chips into the filter
// - IF loopback feeds transmit IF samples into receiver I input
// - overlay select codes off, 63, 511 and 1023 symbol sequences
// - overlay bit removed from I and Q of each symbol received in data mode
// - overlay generator restarts at each burst start
// - mode bit low selects QPSK differential, high selects BPSK
// - BPSK requests one bit per symbol one chip before end
// - QPSK requests twice, one chip before mid and before end
// - request leads latch by one chip and drops at the latch edge
// - offset-binary bit inverts the IF output MSB
// - manual chip bit selects external pulses or internal divider
// - manual chip pulse is synchronised and edge detected
// - invert-symbol bit inverts I and Q after differential encoding
// - internal chip rate is clock divided by n plus one
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "modem_ctrl_defines.svh"
module burst_modem_test_tx_control (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          rx_enable_pin,
    input  wire modem_ctrl_pkg::probe_points_t rx_probe_points,
    output logic      [7:0]                    rx_probe_bus,
    output logic      [7:0]                    mf_section_power,
    input  wire logic                          rx_preamble_det,
    input  wire logic                          rx_symbol_strobe,
    input  wire logic                          rx_sym_i,
    input  wire logic                          rx_sym_q,
    output logic                               rx_data_i,
    output logic                               rx_data_q,
    output logic                               rx_data_valid,
    output logic                               rx_acq_mode,
    input  wire logic                          mf_i_ext,
    input  wire logic                          mf_q_ext,
    output logic                               mf_i_in,
    output logic                               mf_q_in,
    input  wire modem_ctrl_pkg::sample_t       rx_i_sample_in,
    output modem_ctrl_pkg::sample_t            rx_i_sample,
    input  wire logic                          tx_enable_pin,
    input  wire logic                          manual_chip_pulse,
    input  wire logic                          tx_serial_in,
    output logic                               tx_bit_request,
    input  wire logic                          tx_pn_chip,
    output logic                               tx_i_chip_out,
    output logic                               tx_q_chip_out,
    input  wire modem_ctrl_pkg::sample_t       tx_if_mod,
    output modem_ctrl_pkg::sample_t            tx_if_sample_out
);
    import modem_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0]  burst_lo;
        logic [7:0]  burst_hi;
        logic [3:0]  probe_sel;
        logic [6:0]  pwr_off;
        logic [3:0]  lb_ctrl;
        logic [3:0]  tx_mode;
        logic [5:0]  chip_div;
        logic [5:0]  chips_sym;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        rx_mode_e    rx_mode;
        logic [15:0] sym_cnt;
        logic [7:0]  probe_bus;
        logic [7:0]  mf_pwr;
        logic        data_i;
        logic        data_q;
        logic        data_valid;
        logic        mf_i;
        logic        mf_q;
        logic [7:0]  rx_i_smp;
        logic        mchp_s1;
        logic        mchp_s2;
        logic        mchp_s3;
        logic [5:0]  chip_idx;
        logic        req;
        logic        first_i;
        logic        enc_i;
        logic        enc_q;
        logic        i_chip;
        logic        q_chip;
        logic [7:0]  if_out;
    } top_state_s;

    top_state_s st;
    top_state_s next_st;

    overlay_if  ovl ();
    chip_div_if cdv ();

    overlay_gen u_overlay (
        .pclk    (pclk),
        .presetn (presetn),
        .ov      (ovl.gen)
    );

    chip_divider u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .cd      (cdv.gen)
    );

    logic [7:0]  idx;
    logic        addr_ok;
    logic        wr_fire;
    logic [7:0]  rd_byte;
    logic [7:0]  wb;
    logic [15:0] burst_len;
    logic [15:0] sym_next;
    logic        chip_en;
    logic        qpsk;
    logic [5:0]  nidx;
    logic [5:0]  half;
    logic        end_latch;
    logic        mid_latch;
    logic        req_set;
    logic        sym_i;
    logic        sym_q;

    assign idx       = paddr[9:2];
    assign wb        = pwdata[7:0];
    assign burst_len = {st.burst_hi, st.burst_lo};
    assign qpsk      = !st.tx_mode[`TXM_BPSK_BIT];
    assign chip_en   = st.tx_mode[`TXM_MANUAL_CHIP_BIT] ?
                       (st.mchp_s2 & !st.mchp_s3) : cdv.tick;
    assign nidx      = (st.chip_idx == st.chips_sym) ? 6'h00 :
                       st.chip_idx + 6'h01;
    assign half      = 6'((7'(st.chips_sym) + 7'h01) >> 1);
    assign end_latch = chip_en && (st.chip_idx == st.chips_sym);
    assign mid_latch = chip_en && qpsk && (nidx == half);
    assign req_set   = chip_en && tx_enable_pin &&
                       ((nidx == st.chips_sym) ||
                        (qpsk && nidx == half - 6'h01));
    assign sym_i     = st.enc_i ^ st.tx_mode[`TXM_INVERT_SYM_BIT];
    assign sym_q     = st.enc_q ^ st.tx_mode[`TXM_INVERT_SYM_BIT];

    assign cdv.div = st.chip_div;
    assign cdv.run = tx_enable_pin;

    assign ovl.sel     = overlay_sel_e'(st.lb_ctrl[`OVL_SEL_LSB +: 2]);
    assign ovl.restart = (st.rx_mode == RX_ACQ) && rx_preamble_det;
    assign ovl.step    = (st.rx_mode == RX_DATA) && rx_symbol_strobe;

    // unused bits are never stored, so they read back as zero
    always_comb begin
        addr_ok = 1'b1;
        rd_byte = `RST_BYTE;
        case (idx)
            `IDX_RX_BURST_LEN_LOW:         rd_byte = st.burst_lo;
            `IDX_RX_BURST_LEN_HIGH:        rd_byte = st.burst_hi;
            `IDX_RX_PROBE_SELECT:          rd_byte = {4'h0, st.probe_sel};
            `IDX_FILTER_SECTION_POWER_OFF: rd_byte = {1'b0, st.pwr_off};
            `IDX_LOOPBACK_OVERLAY_CTRL:    rd_byte = {4'h0, st.lb_ctrl};
            `IDX_TX_MODE_CTRL:             rd_byte = {4'h0, st.tx_mode};
            `IDX_TX_CHIP_DIVIDER:          rd_byte = {2'h0, st.chip_div};
            `IDX_TX_CHIPS_PER_SYMBOL:      rd_byte = {2'h0, st.chips_sym};
            `IDX_BLOCK_STATUS:
                rd_byte = {6'h00, st.req, st.rx_mode == RX_ACQ};
            default:                       addr_ok = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end
    end

    assign wr_fire = psel && penable && st.pready && pwrite && addr_ok;

    always_comb begin
        next_st  = st;
        sym_next = st.sym_cnt + 16'h0001;

        // one wait state: pready rises in the second access cycle
        next_st.pready  = psel && penable && !st.pready;
        next_st.pslverr = psel && penable && !st.pready && !addr_ok;
        if (psel && penable && !st.pready) begin
            next_st.prdata = {24'h000000, rd_byte};
        end

        if (wr_fire) begin
            case (idx)
                `IDX_RX_BURST_LEN_LOW:         next_st.burst_lo = wb;
                `IDX_RX_BURST_LEN_HIGH:        next_st.burst_hi = wb;
                `IDX_RX_PROBE_SELECT:          next_st.probe_sel = wb[3:0];
                `IDX_FILTER_SECTION_POWER_OFF: next_st.pwr_off = wb[6:0];
                `IDX_LOOPBACK_OVERLAY_CTRL:    next_st.lb_ctrl = wb[3:0];
                `IDX_TX_MODE_CTRL:             next_st.tx_mode = wb[3:0];
                `IDX_TX_CHIP_DIVIDER:          next_st.chip_div = wb[5:0];
                `IDX_TX_CHIPS_PER_SYMBOL:      next_st.chips_sym = wb[5:0];
                default:                       next_st.burst_lo = st.burst_lo;
            endcase
        end

        // receiver burst control
        next_st.data_valid = 1'b0;
        case (st.rx_mode)
            RX_ACQ: begin
                if (rx_preamble_det) begin
                    next_st.rx_mode = RX_DATA;
                    next_st.sym_cnt = 16'h0000;
                end
            end
            RX_DATA: begin
                if (rx_symbol_strobe) begin
                    next_st.sym_cnt    = sym_next;
                    next_st.data_i     = rx_sym_i ^ ovl.code_bit;
                    next_st.data_q     = rx_sym_q ^ ovl.code_bit;
                    next_st.data_valid = 1'b1;
                    if (sym_next >= burst_len - `BURST_OVERHEAD) begin
                        next_st.rx_mode = RX_ACQ;
                    end
                end
            end
            default: next_st.rx_mode = RX_ACQ;
        endcase
        // a disabled receiver always restarts in acquisition
        if (!rx_enable_pin) begin
            next_st.rx_mode   = RX_ACQ;
            next_st.probe_sel = 4'h0;
        end

        next_st.probe_bus = rx_probe_points[{st.probe_sel, 3'h0} +: 8];
        next_st.mf_pwr    = (st.rx_mode == RX_ACQ) ? 8'hFF :
                            {~st.pwr_off, 1'b1};
        next_st.mf_i      = st.lb_ctrl[`LB_MF_BIT] ? st.i_chip : mf_i_ext;
        next_st.mf_q      = st.lb_ctrl[`LB_MF_BIT] ? st.q_chip : mf_q_ext;
        next_st.rx_i_smp  = st.lb_ctrl[`LB_IF_BIT] ? st.if_out :
                            rx_i_sample_in;

        // manual chip pulse synchroniser and edge stage
        next_st.mchp_s1 = manual_chip_pulse;
        next_st.mchp_s2 = st.mchp_s1;
        next_st.mchp_s3 = st.mchp_s2;

        // transmit symbol timing and data request
        if (chip_en) begin
            next_st.chip_idx = nidx;
            next_st.i_chip   = sym_i ^ tx_pn_chip;
            next_st.q_chip   = sym_q ^ tx_pn_chip;
        end
        if (mid_latch) begin
            next_st.first_i = tx_serial_in;
        end
        if (end_latch) begin
            if (qpsk) begin
                next_st.enc_i = st.enc_i ^ st.first_i;
                next_st.enc_q = st.enc_q ^ tx_serial_in;
            end else begin
                next_st.enc_i = st.enc_i ^ tx_serial_in;
                next_st.enc_q = st.enc_i ^ tx_serial_in;
            end
        end
        // a new request wins over the drop at the same edge
        if (req_set) begin
            next_st.req = 1'b1;
        end else if (end_latch || mid_latch) begin
            next_st.req = 1'b0;
        end
        next_st.if_out = tx_if_mod ^
                         (st.tx_mode[`TXM_OFFSET_BIN_BIT] ?
                          `IF_MSB_FLIP : 8'h00);
        if (!tx_enable_pin) begin
            next_st.chip_idx = 6'h00;
            next_st.req      = 1'b0;
            next_st.enc_i    = 1'b0;
            next_st.enc_q    = 1'b0;
            next_st.first_i  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.rx_mode   <= RX_ACQ;
            st.chip_div  <= `RST_CHIP_DIVIDER;
            st.chips_sym <= `RST_CHIPS_PER_SYMBOL;
            st.mf_pwr    <= 8'hFF;
        end else begin
            st <= next_st;
        end
    end

    assign prdata           = st.prdata;
    assign pready           = st.pready;
    assign pslverr          = st.pslverr;
    assign rx_probe_bus     = st.probe_bus;
    assign mf_section_power = st.mf_pwr;
    assign rx_data_i        = st.data_i;
    assign rx_data_q        = st.data_q;
    assign rx_data_valid    = st.data_valid;
    assign rx_acq_mode      = (st.rx_mode == RX_ACQ);
    assign mf_i_in          = st.mf_i;
    assign mf_q_in          = st.mf_q;
    assign rx_i_sample      = st.rx_i_smp;
    assign tx_bit_request   = st.req;
    assign tx_i_chip_out    = st.i_chip;
    assign tx_q_chip_out    = st.q_chip;
    assign tx_if_sample_out = st.if_out;
endmodule

// [verif/tx_data_source.sv]
// model of the logic that feeds transmit data bits on request
// assumes the request rises at a chip edge and stands one chip period
`timescale 1ns/1ns
module tx_data_source (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tx_bit_request,
    output logic      tx_serial_in
);
    logic       req_q;
    logic [7:0] pat;

    // the bit is shown one clock after the request, well inside the chip;
    // once taken the line is spoiled so a late latch cannot pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q        <= 1'h0;
            pat          <= 8'hB4;
            tx_serial_in <= 1'h0;
        end else begin
            req_q <= tx_bit_request;
            if (tx_bit_request && !req_q) begin
                tx_serial_in <= pat[7];
                pat          <= {pat[6:0], pat[7]};
            end else if (!tx_bit_request && req_q) begin
                tx_serial_in <= ~tx_serial_in;
            end
        end
    end
endmodule

// [verif/burst_modem_test_tx_control_sva.sv]
// port checker for the burst modem control block
// assumes single clock pclk and asynchronous active-low presetn
`timescale 1ns/1ns
module burst_modem_test_tx_control_sva (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pready,
    input wire logic                          rx_enable_pin,
    input wire modem_ctrl_pkg::probe_points_t rx_probe_points,
    input wire logic [7:0]                    rx_probe_bus,
    input wire logic [7:0]                    mf_section_power,
    input wire logic                          rx_symbol_strobe,
    input wire logic                          rx_data_valid,
    input wire logic                          rx_acq_mode,
    input wire logic                          tx_enable_pin,
    input wire logic                          tx_bit_request,
    input wire modem_ctrl_pkg::sample_t       tx_if_mod,
    input wire modem_ctrl_pkg::sample_t       tx_if_sample_out
);
    import modem_ctrl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_apb_wait:
        assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse:
        assert property (pready |=> !pready)
        else $error("pready held");
    chk_acq_power:
        assert property (rx_acq_mode && $past(rx_acq_mode)
                         |-> mf_section_power == 8'hFF)
        else $error("section off in acquisition");
    chk_tap0_on:
        assert property (mf_section_power[0])
        else $error("tap zero off");
    // a disabled receiver must fall back to test point zero
    chk_probe_clear:
        assert property (!rx_enable_pin ##1 !rx_enable_pin
                         |=> rx_probe_bus == $past(rx_probe_points[7:0]))
        else $error("probe select not cleared");
    chk_sym_valid:
        assert property (rx_symbol_strobe && !rx_acq_mode |=> rx_data_valid)
        else $error("symbol dropped");
    chk_txen_clear:
        assert property (!tx_enable_pin |=> !tx_bit_request)
        else $error("request without enable");
    chk_req_width:
        assert property ($rose(tx_bit_request) && tx_enable_pin
                         |=> tx_bit_request)
        else $error("request shorter than a chip");
    chk_if_low:
        assert property ($past(presetn)
                         |-> tx_if_sample_out[6:0] == $past(tx_if_mod[6:0]))
        else $error("if sample low bits wrong");

    cover property (!rx_acq_mode ##1 rx_acq_mode);
    cover property ($rose(tx_bit_request));
    cover property (psel && penable && pready);
endmodule

bind burst_modem_test_tx_control burst_modem_test_tx_control_sva u_chk (.*);

// [verif/burst_modem_test_tx_control_bench.sv]
// self-checking bench for the burst modem control block
// assumes the design answers apb with one wait state, pclk at 100 MHz
`timescale 1ns/1ns
module burst_modem_test_tx_control_bench;
    import modem_ctrl_pkg::*;
    logic          pclk, pready, pslverr, rx_data_i, rx_data_q, e;
    logic          presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic          pwrite = 1'h0, rx_enable_pin = 1'h1, rx_sym_i = 1'h0;
    logic          rx_preamble_det = 1'h0, rx_symbol_strobe = 1'h0;
    logic          mf_i_ext = 1'h0, mf_q_ext = 1'h0, tx_enable_pin = 1'h0;
    logic          manual_chip_pulse = 1'h0, tx_pn_chip = 1'h0;
    logic          rx_sym_q = 1'h0;
    logic          rx_data_valid, rx_acq_mode, mf_i_in, mf_q_in;
    logic          tx_serial_in, tx_bit_request, tx_i_chip_out, tx_q_chip_out;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0, prdata, r;
    logic [7:0]    rx_probe_bus, mf_section_power;
    probe_points_t rx_probe_points;
    sample_t       rx_i_sample_in = 8'h00, tx_if_mod = 8'h00;
    sample_t       rx_i_sample, tx_if_sample_out;
    int            n_fail = 0, checks_done = 0, cyc = 0, mcnt = 0;

    burst_modem_test_tx_control u_dut (.*);
    tx_data_source u_src (.*);

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // manual chip pulses every ten clocks; only heard in manual mode
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        mcnt <= (mcnt == 4) ? 0 : mcnt + 1;
        if (mcnt == 4) manual_chip_pulse <= ~manual_chip_pulse;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    function automatic logic [7:0] pt(input int k);
        return {k[3:0], ~k[3:0]};
    endfunction

    task give_verdict;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) n_fail++;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d);
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] x);
        apb(1'h0, idx, 8'h00);
        chk({e, r}, {25'h0, x});
    endtask

    task t_regs;
        logic [7:0] ix [6] = '{8'h2E, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h40};
        logic [7:0] mk [6] = '{8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'h0F, 8'h0F};
        for (int i = 0; i < 6; i++) begin
            rd(ix[i], 8'h00);
            wr(ix[i], 8'hFF);
            rd(ix[i], mk[i]);
            wr(ix[i], 8'h00);
        end
        apb(1'h0, 8'h3C, 8'h00);
        chk({e, r}, {1'h1, 32'h0});
    endtask

    task t_probe;
        for (int k = 0; k < 16; k++) begin
            wr(8'h38, 8'(k));
            repeat (2) @(posedge pclk);
            #1;
            chk(33'(rx_probe_bus), 33'(pt(k)));
        end
        @(posedge pclk);
        rx_enable_pin <= 1'h0;
        repeat (8) @(posedge pclk);
        rx_enable_pin <= 1'h1;
        rd(8'h38, 8'h00);
    endtask

    task sym(input logic b, input logic acq, input logic ck, input logic d);
        @(posedge pclk);
        rx_symbol_strobe <= 1'h1;
        rx_sym_i <= b;
        rx_sym_q <= ~b;
        @(posedge pclk);
        rx_symbol_strobe <= 1'h0;
        #1;
        chk({rx_data_valid, rx_acq_mode}, {1'h1, acq});
        if (ck) chk(33'({rx_data_i, rx_data_q}), 33'({d, ~d}));
    endtask

    // overlay seeds all ones, so the first symbol of a burst is inverted
    task t_rx;
        wr(8'h39, 8'h55);
        wr(8'h2E, 8'h05);
        chk(33'(mf_section_power), 33'hFF);
        for (int s = 0; s < 4; s++) begin
            wr(8'h3B, 8'(s << 2));
            @(posedge pclk);
            rx_preamble_det <= 1'h1;
            @(posedge pclk);
            rx_preamble_det <= 1'h0;
            repeat (2) @(posedge pclk);
            #1;
            chk(33'(mf_section_power), 33'h55);
            sym(1'h1, 1'h0, 1'h1, 1'(s == 0));
            sym(1'h0, 1'h0, 1'h0, 1'h0);
            sym(1'h1, 1'h1, 1'h0, 1'h0);
        end
        wr(8'h39, 8'h00);
    endtask

    task t_loop;
        @(posedge pclk);
        mf_i_ext <= 1'h1;
        mf_q_ext <= 1'h1;
        tx_if_mod <= 8'h12;
        rx_i_sample_in <= 8'h34;
        wr(8'h3B, 8'h01);
        repeat (2) @(posedge pclk);
        #1;
        chk({mf_i_in, mf_q_in}, 33'h0);
        wr(8'h3B, 8'h02);
        wr(8'h40, 8'h02);
        repeat (3) @(posedge pclk);
        #1;
        chk({mf_i_in, mf_q_in, rx_i_sample, tx_if_sample_out}, 33'h39292);
        wr(8'h3B, 8'h00);
        wr(8'h40, 8'h0C);
        repeat (12) @(posedge pclk);
        #1;
        chk({tx_i_chip_out, tx_q_chip_out}, 33'h3);
        wr(8'h40, 8'h00);
        repeat (3) @(posedge pclk);
        #1;
        chk(33'(rx_i_sample), 33'h34);
    endtask

    task run(input logic v, inout int n);
        while (tx_bit_request === v && n < 200) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task meas(input int per, input int wid);
        int w, p;
        p = 0;
        w = 0;
        run(1'h0, p);
        run(1'h1, w);
        p = w;
        run(1'h0, p);
        chk(33'(w), 33'(wid));
        chk(33'(p), 33'(per));
    endtask

    // four chips per symbol: bpsk, qpsk, slower divider, manual chips
    task t_tx;
        logic [7:0] md [4] = '{8'h01, 8'h00, 8'h01, 8'h05};
        logic [7:0] dv [4] = '{8'h01, 8'h01, 8'h02, 8'h01};
        int         pr [4] = '{8, 4, 12, 40};
        int         wd [4] = '{2, 2, 3, 10};
        wr(8'h42, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr(8'h40, md[i]);
            wr(8'h41, dv[i]);
            @(posedge pclk);
            tx_enable_pin <= 1'h1;
            meas(pr[i], wd[i]);
            @(posedge pclk);
            tx_enable_pin <= 1'h0;
        end
    endtask

    initial begin
        for (int k = 0; k < 16; k++) rx_probe_points[8*k +: 8] = pt(k);
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_probe();
        t_rx();
        t_loop();
        t_tx();
        give_verdict();
    end
endmodule
